// *** rtl/mtd_tieoff_defaults.sv ***
// Tie-off default loader with software override and lane strobe logic
`timescale 1ns/1ps
`default_nettype none
// Function
// - Load DDR capture scheme from tie
// - Load SDR capture scheme from tie
// - Load SDR capture polarity from tie
// - Load chip select polarities zero-three
// - Load static select one width encoding
// - Polarity zero: reads idle, writes active
// - Polarity one: reads and writes active
// - Software write overrides each default
module mtd_tieoff_defaults
   import mtd_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    reset_n_in,
   input  wire logic                    power_on_reset_n_in,
   input  wire logic [1:0]              ddr_capture_scheme_tie_in,
   input  wire logic                    ddr_capture_polarity_tie_in,
   input  wire logic [1:0]              sdr_capture_scheme_tie_in,
   input  wire logic                    sdr_capture_polarity_tie_in,
   input  wire logic                    static_cs0_polarity_tie_in,
   input  wire logic                    static_cs1_polarity_tie_in,
   input  wire logic                    static_cs2_polarity_tie_in,
   input  wire logic                    static_cs3_polarity_tie_in,
   input  wire logic [1:0]              static_cs1_width_tie_in,
   input  wire logic                    static_cs1_lane_polarity_tie_in,
   input  wire logic                    dyn_read_wr_in,
   input  wire mtd_dyn_read_s           dyn_read_wdata_in,
   input  wire logic [3:0]              static_cfg_wr_in,
   input  wire mtd_static_cfg_s         static_cfg_wdata_in,
   input  wire logic                    cs1_access_in,
   input  wire logic                    cs1_write_in,
   input  wire logic [3:0]              cs1_lanes_in,
   output logic                         loading_out,
   output mtd_dyn_read_s                dyn_read_cfg_out,
   output mtd_static_cfg_s [3:0]        static_cfg_out,
   output logic [3:0]                   byte_lane_strobe_n_out
);
   // ------------------------------------------------------------------
   // Tie gathering
   // ------------------------------------------------------------------
   mtd_dyn_read_s                 dyn_tie;
   logic [NUM_STATIC_CS-1:0]      pol_tie;
   mtd_static_cfg_s [3:0]         static_tie;

   // Reserved DDR ties are passed through; the outside holds them low
   assign dyn_tie.ddr_capture_scheme_field   = ddr_capture_scheme_tie_in;
   assign dyn_tie.ddr_capture_polarity_field = ddr_capture_polarity_tie_in;
   assign dyn_tie.sdr_capture_scheme_field   = sdr_capture_scheme_tie_in;
   assign dyn_tie.sdr_capture_polarity_field = sdr_capture_polarity_tie_in;
   assign pol_tie = {static_cs3_polarity_tie_in, static_cs2_polarity_tie_in,
                     static_cs1_polarity_tie_in, static_cs0_polarity_tie_in};

   // Only select 1 has width and lane ties; others default to 8-bit
   genvar g;
   generate
      for (g = 0; g < NUM_STATIC_CS; g++) begin : g_tie
         if (g == 1) begin : g_cs1
            assign static_tie[g] = '{pol_tie[g],
                                     static_cs1_width_tie_in,
                                     static_cs1_lane_polarity_tie_in};
         end else begin : g_other
            assign static_tie[g] = '{pol_tie[g], WIDTH_8, 1'b0};
         end
      end
   endgenerate

   // Reserved width code is never stored
   function automatic logic [1:0] legal_width(input logic [1:0] w);
      legal_width = (w == WIDTH_RSVD) ? WIDTH_FALLBACK : w;
   endfunction

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   mtd_state_e              state_q, state_d;
   mtd_dyn_read_s           dyn_q, dyn_d;
   mtd_static_cfg_s [3:0]   st_q, st_d;

   // Power-on reset reloads ties; bus reset keeps written values
   always_comb begin
      state_d = state_q;
      dyn_d   = dyn_q;
      st_d    = st_q;
      case (state_q)
         MTD_LOAD: begin
            if (power_on_reset_n_in) begin
               state_d = MTD_RUN;
            end
         end
         MTD_RUN: begin
            if (!reset_n_in) begin
               state_d = MTD_HOLD;
            end
         end
         MTD_HOLD: begin
            if (reset_n_in) begin
               state_d = MTD_RUN;
            end
         end
         default: begin
            state_d = MTD_LOAD;
         end
      endcase
      if (!power_on_reset_n_in) begin
         state_d = MTD_LOAD;
         dyn_d   = dyn_tie;
         for (int i = 0; i < NUM_STATIC_CS; i++) begin
            st_d[i] = static_tie[i];
            st_d[i].memory_width_field =
               legal_width(static_tie[i].memory_width_field);
         end
      end else if (state_q == MTD_RUN && reset_n_in) begin
         // Writes only while running; ties are not resampled
         // A write that meets the bus reset edge is refused
         if (dyn_read_wr_in) begin
            dyn_d = dyn_read_wdata_in;
         end
         for (int i = 0; i < NUM_STATIC_CS; i++) begin
            if (static_cfg_wr_in[i]) begin
               st_d[i] = static_cfg_wdata_in;
               st_d[i].memory_width_field =
                  legal_width(static_cfg_wdata_in.memory_width_field);
            end
         end
      end
   end

   // Registers carry no reset term: the bus reset must not clear them
   always_ff @(posedge clk_in) begin
      state_q <= state_d;
      dyn_q   <= dyn_d;
      st_q    <= st_d;
   end

   // ------------------------------------------------------------------
   // Byte lane strobes for static select 1
   // ------------------------------------------------------------------
   logic [3:0] lanes_d, lanes_q;

   // Idle high; reads follow lane polarity, writes always active
   always_comb begin
      lanes_d = LANES_IDLE;
      if (reset_n_in && power_on_reset_n_in && cs1_access_in) begin
         if (cs1_write_in || st_q[1].byte_lane_polarity_field) begin
            lanes_d = ~cs1_lanes_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         lanes_q <= LANES_IDLE;
      end else begin
         lanes_q <= lanes_d;
      end
   end

   assign loading_out            = (state_q != MTD_RUN);
   assign dyn_read_cfg_out       = dyn_q;
   assign static_cfg_out         = st_q;
   assign byte_lane_strobe_n_out = lanes_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence por_held;
      !power_on_reset_n_in;
   endsequence

   dyn_load_a: assert property (@(posedge clk_in)
      por_held |=> dyn_q.ddr_capture_scheme_field ==
                   $past(ddr_capture_scheme_tie_in))
      else $error("DDR scheme not loaded from tie");
   sdr_load_a: assert property (@(posedge clk_in)
      por_held |=> dyn_q.sdr_capture_scheme_field ==
                   $past(sdr_capture_scheme_tie_in))
      else $error("SDR scheme not loaded from tie");
   sdr_pol_a: assert property (@(posedge clk_in)
      por_held |=> dyn_q.sdr_capture_polarity_field ==
                   $past(sdr_capture_polarity_tie_in))
      else $error("SDR polarity not loaded from tie");
   cs_pol_a: assert property (@(posedge clk_in)
      por_held |=> st_q[3].chip_select_polarity_field ==
                   $past(static_cs3_polarity_tie_in))
      else $error("Chip select polarity not loaded");
   cs1_width_a: assert property (@(posedge clk_in)
      por_held ##0 (static_cs1_width_tie_in != WIDTH_RSVD) |=>
         st_q[1].memory_width_field == $past(static_cs1_width_tie_in))
      else $error("Width not loaded from tie");
   read_idle_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in || !power_on_reset_n_in)
      (cs1_access_in && !cs1_write_in &&
       !st_q[1].byte_lane_polarity_field) |=>
         byte_lane_strobe_n_out == LANES_IDLE)
      else $error("Read strobes not idle");
   read_act_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in || !power_on_reset_n_in)
      (cs1_access_in && st_q[1].byte_lane_polarity_field) |=>
         byte_lane_strobe_n_out == ~$past(cs1_lanes_in))
      else $error("Active lanes not driven low");
   sw_write_a: assert property (@(posedge clk_in)
      disable iff (!power_on_reset_n_in)
      (state_q == MTD_RUN && reset_n_in && dyn_read_wr_in) |=>
         dyn_q == $past(dyn_read_wdata_in))
      else $error("Software write not stored");
   bus_keep_a: assert property (@(posedge clk_in)
      (power_on_reset_n_in && !reset_n_in) ##1 power_on_reset_n_in
         |-> $stable(dyn_q))
      else $error("Bus reset disturbed configuration");
   bus_keep_st_a: assert property (@(posedge clk_in)
      (power_on_reset_n_in && !reset_n_in) |=> $stable(st_q))
      else $error("Bus reset disturbed static configuration");
   load_flag_a: assert property (@(posedge clk_in)
      por_held |=> loading_out)
      else $error("Loading flag low during power-on reset");
endmodule
`default_nettype wire

// *** rtl/mtd_pkg.sv ***
// Package of widths, field layouts and carriers for the tie-off loader
package mtd_pkg;
   // ------------------------------------------------------------------
   // Field widths and encodings
   // ------------------------------------------------------------------
   localparam int         SCHEME_W      = 2;
   localparam int         WIDTH_W       = 2;
   localparam int         LANES         = 4;
   localparam int         NUM_STATIC_CS = 4;
   localparam logic [1:0] WIDTH_8       = 2'h0;
   localparam logic [1:0] WIDTH_16      = 2'h1;
   localparam logic [1:0] WIDTH_32      = 2'h2;
   localparam logic [1:0] WIDTH_RSVD    = 2'h3;
   localparam logic [3:0] LANES_IDLE    = 4'hf;
   // Value held when the width field carries the reserved code
   localparam logic [1:0] WIDTH_FALLBACK = 2'h0;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] ddr_capture_scheme_field;
      logic       ddr_capture_polarity_field;
      logic [1:0] sdr_capture_scheme_field;
      logic       sdr_capture_polarity_field;
   } mtd_dyn_read_s;

   typedef struct packed {
      logic       chip_select_polarity_field;
      logic [1:0] memory_width_field;
      logic       byte_lane_polarity_field;
   } mtd_static_cfg_s;

   typedef enum logic [2:0] {
      MTD_LOAD = 3'h1,
      MTD_RUN  = 3'h2,
      MTD_HOLD = 3'h4
   } mtd_state_e;
endpackage

// *** tb/mtd_rst_ctrl_model.sv ***
// Reset controller model that supplies the tie-off levels
`timescale 1ns/1ps
`default_nettype none
module mtd_rst_ctrl_model (
   input  wire logic        power_on_reset_n_in,
   input  wire logic [12:0] src_in,
   output logic      [12:0] ties_out
);
   // Levels pass only while power-on reset is low and are held after it,
   // so they never move during normal operation and are defined from the
   // very first clock edge; reserved ties are held low
   always_latch begin
      if (!power_on_reset_n_in) begin
         ties_out <= {3'h0, src_in[9:0]};
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the tie-off default loader
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mtd_pkg::*;
   logic                  clk_in = 1'b0, rst_n = 1'b0, por_n = 1'b0;
   logic                  dwr = 1'b0, acc = 1'b0, wrt = 1'b0;
   logic                  p_acc, p_wrt, load;
   logic [3:0]            swr = 4'h0, lanes = 4'h0, p_lanes, strb_q, e_strb;
   logic [12:0]           src = 13'h0, ties;
   mtd_dyn_read_s         dwd = '0, dyn_q, e_dyn;
   mtd_static_cfg_s       swd = '0, e_st [4];
   mtd_static_cfg_s [3:0] st_q;
   int                    n_fail = 0, checks = 0;

   always #50 clk_in = ~clk_in;

   mtd_rst_ctrl_model prt (.power_on_reset_n_in(por_n), .src_in(src),
      .ties_out(ties));
   mtd_tieoff_defaults uut (.clk_in(clk_in), .reset_n_in(rst_n),
      .power_on_reset_n_in(por_n), .ddr_capture_scheme_tie_in(ties[12:11]),
      .ddr_capture_polarity_tie_in(ties[10]),
      .sdr_capture_scheme_tie_in(ties[9:8]),
      .sdr_capture_polarity_tie_in(ties[7]),
      .static_cs0_polarity_tie_in(ties[3]),
      .static_cs1_polarity_tie_in(ties[4]),
      .static_cs2_polarity_tie_in(ties[5]),
      .static_cs3_polarity_tie_in(ties[6]),
      .static_cs1_width_tie_in(ties[2:1]),
      .static_cs1_lane_polarity_tie_in(ties[0]), .dyn_read_wr_in(dwr),
      .dyn_read_wdata_in(dwd), .static_cfg_wr_in(swr),
      .static_cfg_wdata_in(swd), .cs1_access_in(acc), .cs1_write_in(wrt),
      .cs1_lanes_in(lanes), .loading_out(load), .dyn_read_cfg_out(dyn_q),
      .static_cfg_out(st_q), .byte_lane_strobe_n_out(strb_q));

   // ---------------------------------------------------------------
   // Expectations and comparisons
   // ---------------------------------------------------------------
   // Reserved width code is stored as 8-bit
   function automatic mtd_static_cfg_s fix(mtd_static_cfg_s s);
      if (s.memory_width_field == WIDTH_RSVD) begin
         s.memory_width_field = WIDTH_FALLBACK;
      end
      return s;
   endfunction
   function automatic logic [3:0] exp_strb(logic a, w, p, logic [3:0] l);
      return (a && (w || p)) ? ~l : LANES_IDLE;
   endfunction
   task automatic chk(string what, logic [5:0] e, logic [5:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_cfg;
      @(negedge clk_in);
      chk("dyn_read_cfg", e_dyn, dyn_q);
      for (int i = 0; i < 4; i++) begin
         chk("static_cfg", 6'(e_st[i]), 6'(st_q[i]));
      end
      chk("loading", 6'h0, 6'(load));
   endtask
   // Hold power-on reset over several edges so the model's latched ties land
   task automatic por_pulse;
      @(posedge clk_in);
      por_n <= 1'b0;
      repeat (3) @(posedge clk_in);
      por_n <= 1'b1;
      @(negedge clk_in);
      chk("loading", 6'h1, 6'(load));
      repeat (2) @(posedge clk_in);
      e_dyn = ties[12:7];
      for (int i = 0; i < 4; i++) begin
         e_st[i] = fix({ties[3+i], (i == 1) ? ties[2:1] : WIDTH_8,
                        (i == 1) ? ties[0] : 1'b0});
      end
   endtask
   task automatic put_dyn(mtd_dyn_read_s d);
      @(posedge clk_in);
      dwr <= 1'b1;
      dwd <= d;
      @(posedge clk_in);
      dwr <= 1'b0;
      e_dyn = d;
   endtask
   task automatic put_st(int i, mtd_static_cfg_s s);
      @(posedge clk_in);
      swr <= 4'(1 << i);
      swd <= s;
      @(posedge clk_in);
      swr <= 4'h0;
      e_st[i] = fix(s);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [12:0] v;
      void'($urandom(32'hc238));
      repeat (10) @(posedge clk_in);
      rst_n <= 1'b1;
      // Every width code, including the reserved one, with random ties
      for (int k = 0; k < 4; k++) begin
         v = 13'($urandom);
         v[2:1] = 2'(k);
         src <= v;
         por_pulse();
         check_cfg();
      end
      $display("test load done");
      // Software writes replace every default, one write every other cycle
      repeat (4) begin
         put_dyn(6'($urandom));
         for (int i = 0; i < 4; i++) put_st(i, 4'($urandom));
         check_cfg();
      end
      $display("test override done");
      // Lane strobes under both lane polarities, checked every cycle
      for (int p = 0; p < 2; p++) begin
         put_st(1, {e_st[1].chip_select_polarity_field, WIDTH_32, 1'(p)});
         repeat (16) begin
            @(posedge clk_in);
            p_acc = acc;
            p_wrt = wrt;
            p_lanes = lanes;
            acc <= 1'($urandom);
            wrt <= 1'($urandom);
            lanes <= 4'($urandom);
            @(negedge clk_in);
            e_strb = exp_strb(p_acc, p_wrt, 1'(p), p_lanes);
            chk("strobe_n", {2'h0, e_strb}, {2'h0, strb_q});
         end
      end
      $display("test strobes done");
      // Bus reset keeps written values and ignores a write; power-on reloads
      @(posedge clk_in);
      rst_n <= 1'b0;
      {acc, wrt, lanes, dwr} <= {2'h3, 4'h5, 1'b1};
      dwd <= ~e_dyn;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("strobe_n", {2'h0, LANES_IDLE}, {2'h0, strb_q});
      chk("loading", 6'h1, 6'(load));
      @(posedge clk_in);
      {rst_n, dwr, acc} <= 3'h4;
      repeat (2) @(posedge clk_in);
      check_cfg();
      src <= 13'($urandom);
      por_pulse();
      check_cfg();
      $display("test resets done");
      stop_test();
   end

   // Watchdog, far beyond the roughly 120 cycles the tests need
   initial begin
      repeat (2000) @(posedge clk_in);
      n_fail++;
      stop_test();
   end
endmodule
`default_nettype wire
